// >>> shared/adct_pkg.sv
// Purpose: Shared constants, types and helpers for the converter timing block
// Assumes: One clock (CPU clock), converter basic clock made by enable pulses
// Notes:   Selector decodes live here so divider and control agree on them
package adct_pkg;

    // ----------------------------------------------------------------
    // Widths and fixed counts
    // ----------------------------------------------------------------
    localparam int          RES_W       = 10;         // Result width
    localparam int          CNT_W       = 12;         // Wide enough for longest conversion
    localparam logic [6:0]  CONV_BC     = 7'h28;      // Decide phase: 40 basic periods
    localparam logic [1:0]  STEP_LAST   = 2'h3;       // Four basic periods per bit
    localparam logic [CNT_W-1:0] LOAD_CYC = 12'h002;  // Result load: 2 CPU cycles
    localparam logic [3:0]  MSB_IDX     = 4'h9;       // First bit tried
    localparam logic [9:0]  TRIAL_INIT  = 10'h200;    // Mid-scale first trial

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [9:0]  RESULT_RST  = 10'h000;    // Result after reset
    localparam logic [1:0]  SEL_RST     = 2'h0;       // Captured selectors after reset

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONV,
        ST_LOAD
    } adct_state_t;

    // ----------------------------------------------------------------
    // Selector decodes
    // ----------------------------------------------------------------
    // Basic clock divide ratio from basic_clock_select
    function automatic logic [4:0] adct_div_of(input logic [1:0] sel);
        unique case (sel)
            2'h0: adct_div_of = 5'h04;
            2'h1: adct_div_of = 5'h02;
            2'h2: adct_div_of = 5'h10;
            2'h3: adct_div_of = 5'h08;
        endcase
    endfunction : adct_div_of

    // Sample window in basic periods from sample_time_select
    function automatic logic [6:0] adct_ts_of(input logic [1:0] sel);
        unique case (sel)
            2'h0: adct_ts_of = 7'h08;
            2'h1: adct_ts_of = 7'h10;
            2'h2: adct_ts_of = 7'h20;
            2'h3: adct_ts_of = 7'h40;
        endcase
    endfunction : adct_ts_of

endpackage : adct_pkg

// >>> rtl/adct_bc_div.sv
// Purpose: Basic clock enable divider for the converter sequencer
// Assumes: run low between conversions; sel stable while run is high
// Notes:   Counter restarts from zero on each run so phases align to start
`timescale 1ns/1ps
module adct_bc_div (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        run,
    input  wire logic [1:0]  sel,
    output logic             tick
);
    import adct_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] cnt;            // CPU cycles within one basic period
    } adct_div_st_t;

    adct_div_st_t s_q;              // Registered state
    adct_div_st_t s_d;              // Next state
    logic [4:0]   last;             // Final count of a period

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // Tick on the last CPU cycle of each basic period
    always_comb begin
        last  = adct_div_of(sel) - 5'h01;
        tick  = run && ({1'b0, s_q.cnt} == last);
        s_d   = s_q;
        if (!run || tick) begin
            s_d.cnt = 4'h0;                       // Idle or wrap: restart period
        end else begin
            s_d.cnt = s_q.cnt + 4'h1;
        end
    end

    // Register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : adct_bc_div

// >>> rtl/adct_timing.sv
// Purpose: Conversion sequencer for a 10-bit successive-approximation converter
// Assumes: Comparator and sample switch are analog, across the pins
// Notes:   One conversion at a time; start is ignored while busy
//
// Functional notes
// - Basic clock: CPU divided by 4,2,16,8
// - Sample window: 8,16,32,64 basic periods
// - Conversion exactly window+40 basic+2 CPU
// - Sample, decide, then load result register
// - Below ground reads zero, above reference 3FF
// - Input held after the sample window
`timescale 1ns/1ps
module adct_timing (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        start,
    input  wire logic [1:0]  basic_clock_select,
    input  wire logic [1:0]  sample_time_select,
    input  wire logic        cmp_above,
    output logic             busy,
    output logic             sample_track,
    output logic [9:0]       trial_code,
    output logic [9:0]       result,
    output logic             done
);
    import adct_pkg::*;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_s1_q;                 // First release stage
    logic rst_n_q;                  // Reset copy used by the design

    // Release is synchronous so no flop sees a ragged deassert
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        adct_state_t state;         // Sequencer phase
        logic [1:0]  clk_sel;       // Captured basic clock select
        logic [1:0]  smp_sel;       // Captured sample time select
        logic [6:0]  cnt;           // Basic periods within phase
        logic        load_cnt;      // CPU cycle within load
        logic [3:0]  idx;           // Bit under decision
        logic [9:0]  trial;         // Approximation register
        logic [9:0]  result;        // Result register
        logic        done;          // End of conversion pulse
        logic        cmp_s1;        // Comparator sync, first stage
        logic        cmp_s2;        // Comparator sync, second stage
    } adct_st_t;

    adct_st_t    s_q;               // Registered state
    adct_st_t    s_d;               // Next state
    logic        bc_tick;           // One basic clock period elapsed
    logic        div_run;           // Divider runs during timed phases

    assign div_run = (s_q.state == ST_SAMPLE) || (s_q.state == ST_CONV);

    // ----------------------------------------------------------------
    // Basic clock divider
    // ----------------------------------------------------------------
    adct_bc_div u_div (
        .clk   (clk),
        .rst_n (rst_n_q),
        .run   (div_run),
        .sel   (s_q.clk_sel),
        .tick  (bc_tick)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        s_d        = s_q;
        s_d.done   = 1'b0;
        s_d.cmp_s1 = cmp_above;                   // Pin passes two flops
        s_d.cmp_s2 = s_q.cmp_s1;
        unique case (s_q.state)
            // Wait for start; selectors are taken only here
            ST_IDLE: begin
                if (start) begin
                    s_d.state   = ST_SAMPLE;
                    s_d.clk_sel = basic_clock_select;
                    s_d.smp_sel = sample_time_select;
                    s_d.cnt     = 7'h00;
                end
            end
            // Track the input for the programmed window
            ST_SAMPLE: begin
                if (bc_tick) begin
                    if (s_q.cnt == adct_ts_of(s_q.smp_sel) - 7'h01) begin
                        s_d.state = ST_CONV;
                        s_d.cnt   = 7'h00;
                        s_d.idx   = MSB_IDX;
                        s_d.trial = TRIAL_INIT;
                    end else begin
                        s_d.cnt = s_q.cnt + 7'h01;
                    end
                end
            end
            // One bit decided every four basic periods
            ST_CONV: begin
                if (bc_tick) begin
                    s_d.cnt = s_q.cnt + 7'h01;
                    if (s_q.cnt[1:0] == STEP_LAST) begin
                        // Comparator low means input is below trial level
                        if (!s_q.cmp_s2) begin
                            s_d.trial[s_q.idx] = 1'b0;
                        end
                        if (s_q.idx != 4'h0) begin
                            s_d.trial[s_q.idx - 4'h1] = 1'b1;
                            s_d.idx = s_q.idx - 4'h1;
                        end
                    end
                    if (s_q.cnt == CONV_BC - 7'h01) begin
                        s_d.state    = ST_LOAD;
                        s_d.load_cnt = 1'b0;
                    end
                end
            end
            // Two CPU cycles, then the result register takes the code
            ST_LOAD: begin
                s_d.load_cnt = 1'b1;
                if (s_q.load_cnt) begin
                    s_d.state  = ST_IDLE;
                    s_d.result = s_q.trial;
                    s_d.done   = 1'b1;
                end
            end
        endcase
    end

    // Register
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s_q         <= '0;
            s_q.state   <= ST_IDLE;
            s_q.clk_sel <= SEL_RST;
            s_q.smp_sel <= SEL_RST;
            s_q.result  <= RESULT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign busy         = (s_q.state != ST_IDLE);
    assign sample_track = (s_q.state == ST_SAMPLE); // Hold once window ends
    assign trial_code   = s_q.trial;
    assign result       = s_q.result;
    assign done         = s_q.done;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] cyc_q;        // CPU cycles since start taken
    logic [CNT_W-1:0] ph_q;         // CPU cycles in current phase
    logic [4:0]       gap_q;        // CPU cycles since last tick
    logic             any_hi_q;     // Comparator seen high in decide phase
    logic             any_lo_q;     // Comparator seen low in decide phase
    logic [CNT_W-1:0] div_w;        // Captured divide ratio, widened
    logic [CNT_W-1:0] ts_w;         // Captured window, widened

    assign div_w = {7'h00, adct_div_of(s_q.clk_sel)};
    assign ts_w  = {5'h00, adct_ts_of(s_q.smp_sel)};

    // Helper counters only the checks read
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cyc_q    <= '0;
            ph_q     <= '0;
            gap_q    <= '0;
            any_hi_q <= 1'b0;
            any_lo_q <= 1'b0;
        end else begin
            cyc_q    <= busy ? cyc_q + 12'h001 : 12'h000;
            ph_q     <= (s_d.state != s_q.state) ? 12'h000 : ph_q + 12'h001;
            gap_q    <= (bc_tick || !div_run) ? 5'h01 : gap_q + 5'h01;
            any_hi_q <= (s_q.state == ST_CONV) ? (any_hi_q | s_q.cmp_s2) : 1'b0;
            any_lo_q <= (s_q.state == ST_CONV) ? (any_lo_q | !s_q.cmp_s2) : 1'b0;
        end
    end

    sequence seq_decide_end;
        (s_q.state == ST_CONV) && bc_tick && (s_q.cnt == CONV_BC - 7'h01);
    endsequence

    sequence seq_load_done;
        (s_q.state == ST_LOAD) [*2] ##1 done;
    endsequence

    AST_BC_PERIOD: assert property (@(posedge clk) disable iff (!rst_n_q)
        bc_tick |-> ({7'h00, gap_q} == div_w))
        else $error("Basic period length wrong");

    AST_SAMPLE_LEN: assert property (@(posedge clk) disable iff (!rst_n_q)
        (s_q.state == ST_SAMPLE) ##1 (s_q.state == ST_CONV)
        |-> $past(ph_q) + 12'h001 == ts_w * div_w)
        else $error("Sample window length wrong");

    AST_CONV_TOTAL: assert property (@(posedge clk) disable iff (!rst_n_q)
        $fell(busy) |-> cyc_q == (ts_w + {5'h00, CONV_BC}) * div_w + LOAD_CYC)
        else $error("Conversion length wrong");

    AST_ORDER: assert property (@(posedge clk) disable iff (!rst_n_q)
        seq_decide_end |=> seq_load_done)
        else $error("Load does not follow decide phase");

    AST_RESULT_HELD: assert property (@(posedge clk) disable iff (!rst_n_q)
        !done |-> $stable(result))
        else $error("Result changed outside load");

    AST_LOW_ZERO: assert property (@(posedge clk) disable iff (!rst_n_q)
        (s_q.state == ST_LOAD) && !s_q.load_cnt && !any_hi_q |=> ##1 result == 10'h000)
        else $error("Underrange result not zero");

    AST_HIGH_FULL: assert property (@(posedge clk) disable iff (!rst_n_q)
        (s_q.state == ST_LOAD) && !s_q.load_cnt && !any_lo_q |=> ##1 result == 10'h3FF)
        else $error("Overrange result not full scale");

    AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n_q)
        $fell(sample_track) |-> !sample_track throughout (busy [*3]))
        else $error("Sample switch reopened in conversion");

    AST_SEL_STABLE: assert property (@(posedge clk) disable iff (!rst_n_q)
        busy && $past(busy) |-> $stable(s_q.clk_sel) && $stable(s_q.smp_sel))
        else $error("Selectors changed during conversion");

endmodule : adct_timing

// >>> bench/adct_ain_model.sv
// Purpose: Analog source, sample capacitor and comparator beside the sequencer
// Assumes: Input level given as a signed code; below 0 or above 3FF is out of range
// Notes:   Comparator output is registered, so it moves one cycle after trial_code
`timescale 1ns/1ps
module adct_ain_model (
    input  wire logic               clk,
    input  wire logic               sample_track,
    input  wire logic [9:0]         trial_code,
    input  wire logic signed [11:0] ain,
    output logic                    cmp_above
);
    // ------------------------------------------------------------
    // Sample switch and comparator
    // ------------------------------------------------------------
    logic signed [11:0] held_q;     // Level on the sample capacitor

    // Known levels from time zero
    initial begin
        held_q    = 12'sh000;
        cmp_above = 1'b0;
    end

    // Capacitor follows the pin only while the switch is closed
    always @(posedge clk) begin
        if (sample_track) begin
            held_q <= ain;
        end
        // High keeps the trial bit; out-of-range levels saturate by themselves
        cmp_above <= (held_q >= $signed({2'h0, trial_code}));
    end
endmodule : adct_ain_model

// >>> bench/adct_timing_bench.sv
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Analog side is the behavioural model beside the sequencer
// Notes:   Clock is a simulation rate, so the basic clock range is not modelled
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("Error at %0t ns: got %0h expected %0h", $time, got, exp); \
        end \
    end
module adct_timing_bench;
    import adct_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic               clk;                 // CPU clock
    logic               arst_n;              // Reset, active low
    logic               start;               // Start request
    logic [1:0]         basic_clock_select;  // Divider code
    logic [1:0]         sample_time_select;  // Window code
    logic signed [11:0] ain;                 // Analog level as a code
    logic               cmp_above;           // Comparator
    logic               busy;
    logic               sample_track;
    logic               done;
    logic [9:0]         trial_code;
    logic [9:0]         result;
    int                 n_errors;
    int                 n_compared;
    int                 n_tests;
    bit                 pend;                // Next start already raised

    adct_timing dut_u (.clk(clk), .arst_n(arst_n), .start(start),
        .basic_clock_select(basic_clock_select), .sample_time_select(sample_time_select),
        .cmp_above(cmp_above), .busy(busy), .sample_track(sample_track),
        .trial_code(trial_code), .result(result), .done(done));
    adct_ain_model ain_u (.clk(clk), .sample_track(sample_track),
        .trial_code(trial_code), .ain(ain), .cmp_above(cmp_above));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Expectations
    // ------------------------------------------------------------
    function automatic int exp_div(input logic [1:0] s);
        case (s)
            2'h0: return 4;
            2'h1: return 2;
            2'h2: return 16;
            default: return 8;
        endcase
    endfunction : exp_div

    // Saturating code for out-of-range levels
    function automatic logic [9:0] exp_code(input int v);
        if (v < 0) return 10'h000;
        if (v > 1023) return 10'h3FF;
        return 10'(v);
    endfunction : exp_code

    // ------------------------------------------------------------
    // One conversion: noise on start and selectors, input jumps after window
    // ------------------------------------------------------------
    task automatic conv(input logic [1:0] bc, input logic [1:0] st, input int v,
                        input int v2, input bit chain);
        int         n;
        int         win;
        int         k;
        int         strk;
        bit         ok;
        logic [9:0] r0;
        begin
            win  = (8 << st) * exp_div(bc);
            n    = win + 40 * exp_div(bc) + 2;
            k    = -1;
            strk = 0;
            ok   = 1'b1;
            r0   = result;
            if (!pend) begin
                @(posedge clk);
                start              <= 1'b1;
                basic_clock_select <= bc;
                sample_time_select <= st;
            end
            pend = 1'b0;
            do begin
                @(posedge clk);
                k++;
                // Early pulses hit a busy sequencer; a chained one lands on done
                start <= (k > 0 && k < n / 2) ? 1'($urandom_range(0, 1))
                                              : 1'(chain && k == n);
                basic_clock_select <= (k < n) ? 2'($urandom) : bc;
                sample_time_select <= (k < n) ? 2'($urandom) : st;
                if (k == 0) ain <= 12'(v);
                if (k == win) ain <= 12'(v2);
                #1;
                if (sample_track === 1'b1) strk++;
                if (done !== 1'b1 && (busy !== 1'b1 || result !== r0)) ok = 1'b0;
            end while (done !== 1'b1 && k < n + 8);
            `CHK(k, n);
            `CHK(strk, win);
            `CHK(ok, 1'b1);
            `CHK(result, exp_code(v));
            pend = chain;
            n_tests++;
            $display("test %0d: codes %0h/%0h level %0d, %0d cycles", n_tests, bc, st, v, k);
        end
    endtask : conv

    // Verdict and end of run
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    // Hang guard, well above the expected run of about 15k cycles
    initial begin
        #200_000;
        n_errors++;
        $display("Error at %0t ns: watchdog expired", $time);
        conclude();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        arst_n = 1'b0; start = 1'b0; ain = 12'sh000; pend = 1'b0;
        basic_clock_select = 2'h0; sample_time_select = 2'h0;
        n_errors = 0; n_compared = 0; n_tests = 0;
        void'($urandom(58));
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK(result, RESULT_RST);
        `CHK(busy, 1'b0);
        // Every divider and window code; basic clock range is a real-rate limit only
        for (int i = 0; i < 16; i++) begin
            conv(2'(i >> 2), 2'(i), $urandom_range(0, 1023), $urandom_range(0, 1023), 1'b0);
        end
        // Out-of-range and end-of-scale levels, far jump after the window
        conv(2'h1, 2'h0, -5, 1023, 1'b0);
        conv(2'h1, 2'h0, 1100, 0, 1'b0);
        conv(2'h0, 2'h0, 0, 1023, 1'b0);
        conv(2'h0, 2'h0, 1023, 0, 1'b0);
        // Back to back: second start on the done cycle
        conv(2'h1, 2'h1, 682, 341, 1'b1);
        conv(2'h1, 2'h1, 341, 682, 1'b0);
        repeat (8) begin
            conv(2'($urandom), 2'($urandom), $urandom_range(0, 1023),
                 $urandom_range(0, 1023), 1'b0);
        end
        conclude();
    end
endmodule : adct_timing_bench
